// ---- rpc_pkg.sv ----
// shared constants and carrier types for the respiration and pace control registers
package rpc_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 24;
  localparam logic [5:0] BREATHING_CONTROL_ADDR = 6'h03;
  localparam logic [5:0] PACER_DETECT_CONTROL_ADDR = 6'h04;
  localparam logic [23:0] BREATHING_CONTROL_RST = 24'h000000;
  localparam logic [23:0] PACER_DETECT_CONTROL_RST = 24'h000f88;
  // breathing control field positions
  localparam int unsigned BR_ON_BIT = 0;
  localparam int unsigned BR_FREQ_LSB = 1;
  localparam int unsigned BR_AMP_LSB = 3;
  localparam int unsigned BR_PATH_LSB = 5;
  localparam int unsigned BR_EXT_BIT = 7;
  localparam int unsigned BR_ALT_BIT = 8;
  localparam logic [23:0] BR_MASK = 24'h0001ff;
  // pacer control field positions
  localparam int unsigned PC_DET_LSB = 0;
  localparam int unsigned PC_SEL1_LSB = 3;
  localparam int unsigned PC_SEL2_LSB = 5;
  localparam int unsigned PC_SEL3_LSB = 7;
  localparam int unsigned PC_VF1_BIT = 9;
  localparam int unsigned PC_VF2_BIT = 10;
  localparam int unsigned PC_PWF_BIT = 11;
  localparam logic [23:0] PC_MASK = 24'h000fff;
  // drive frequencies in units of 0.1 kHz, indexed by the frequency code
  localparam logic [9:0] FREQ_STD_0 = 10'h230;
  localparam logic [9:0] FREQ_STD_1 = 10'h21c;
  localparam logic [9:0] FREQ_STD_2 = 10'h208;
  localparam logic [9:0] FREQ_STD_3 = 10'h1f4;
  localparam logic [9:0] FREQ_ALT_0 = 10'h280;
  localparam logic [9:0] FREQ_ALT_1 = 10'h239;
  localparam logic [9:0] FREQ_ALT_2 = 10'h200;
  localparam logic [9:0] FREQ_ALT_3 = 10'h1d1;
  localparam logic [1:0] AMP_FULL_CODE = 2'h3;
  localparam logic [1:0] LEAD_I = 2'h0;
  localparam logic [1:0] LEAD_II = 2'h1;
  localparam logic [1:0] LEAD_III = 2'h2;
  localparam logic [1:0] LEAD_AVF = 2'h3;

  typedef struct packed {
    logic we;
    logic re;
    logic [5:0] addr;
    logic [23:0] wdata;
  } rpc_req_t;

  typedef struct packed {
    logic pulse_width_filter_on;
    logic validation_filter_two_on;
    logic validation_filter_one_on;
    logic [1:0] detector_three_lead_sel;
    logic [1:0] detector_two_lead_sel;
    logic [1:0] detector_one_lead_sel;
    logic detector_three_on;
    logic detector_two_on;
    logic detector_one_on;
  } rpc_pace_t;

  typedef struct packed {
    logic breathing_measure_on;
    logic alternate_frequency_set;
    logic [1:0] drive_amplitude_sel;
    logic [1:0] drive_frequency_sel;
    logic [1:0] path_sel;
    logic ext_path_sel;
    logic [1:0] amp_shift;
    logic [9:0] drive_freq_x10;
  } rpc_resp_t;
endpackage

// ---- rpc_regs.sv ----
// respiration and pace detection control registers behind the host register port
// Operation
// - amplitude codes 00/01/10 give 1/8,1/4,1/2
// - frequency codes give 56/54/52/50 kHz
// - alternate set gives 64/56.9/51.2/46.5 kHz
// - bit 0 switches breathing measurement on
// - breathing control resets to zero
// - bits 11..9 enable width and validation filters
// - two-bit selectors pick each detector's lead
// - bits 2..0 enable the three detectors
// - pacer control resets to 0x000f88
// - functions exist only on full variant
`timescale 1ns/1ps
module rpc_regs #(
  parameter bit FULL_FEATURE = 1'b1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input rpc_pkg::rpc_req_t req_i,
  output rpc_pkg::rpc_resp_t resp_o,
  output rpc_pkg::rpc_pace_t pace_o,
  output logic [23:0] rdata_o,
  output logic rvalid_o
);
  import rpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [23:0] br_r, br_nxt;
  logic [23:0] pc_r, pc_nxt;
  rpc_resp_t resp_r, resp_nxt;
  logic [23:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic wr_br, wr_pc;

  // reduced variants have no storage to reach, so writes fall away
  assign wr_br = FULL_FEATURE && req_i.we && (req_i.addr == BREATHING_CONTROL_ADDR);
  assign wr_pc = FULL_FEATURE && req_i.we && (req_i.addr == PACER_DETECT_CONTROL_ADDR);

  always_comb begin
    br_nxt = br_r;
    pc_nxt = pc_r;
    if (wr_br) begin
      br_nxt = req_i.wdata & BR_MASK;
    end
    if (wr_pc) begin
      // upper bits are not stored; software is expected to write them as zero
      pc_nxt = req_i.wdata & PC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded drive settings, registered together with the control word
  always_comb begin
    resp_nxt.breathing_measure_on = br_nxt[BR_ON_BIT];
    resp_nxt.alternate_frequency_set = br_nxt[BR_ALT_BIT];
    resp_nxt.drive_amplitude_sel = br_nxt[BR_AMP_LSB +: 2];
    resp_nxt.drive_frequency_sel = br_nxt[BR_FREQ_LSB +: 2];
    resp_nxt.path_sel = br_nxt[BR_PATH_LSB +: 2];
    resp_nxt.ext_path_sel = br_nxt[BR_EXT_BIT];
    // shift of the full drive: 3 for /8 down to 0 for full amplitude
    resp_nxt.amp_shift = AMP_FULL_CODE - br_nxt[BR_AMP_LSB +: 2];
    if (br_nxt[BR_ALT_BIT]) begin
      unique case (br_nxt[BR_FREQ_LSB +: 2])
        2'h0: resp_nxt.drive_freq_x10 = FREQ_ALT_0;
        2'h1: resp_nxt.drive_freq_x10 = FREQ_ALT_1;
        2'h2: resp_nxt.drive_freq_x10 = FREQ_ALT_2;
        2'h3: resp_nxt.drive_freq_x10 = FREQ_ALT_3;
      endcase
    end else begin
      unique case (br_nxt[BR_FREQ_LSB +: 2])
        2'h0: resp_nxt.drive_freq_x10 = FREQ_STD_0;
        2'h1: resp_nxt.drive_freq_x10 = FREQ_STD_1;
        2'h2: resp_nxt.drive_freq_x10 = FREQ_STD_2;
        2'h3: resp_nxt.drive_freq_x10 = FREQ_STD_3;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: one cycle latency, unmapped or reduced variant reads zero
  always_comb begin
    rvalid_nxt = req_i.re;
    rdata_nxt = 24'h000000;
    if (req_i.re && FULL_FEATURE) begin
      if (req_i.addr == BREATHING_CONTROL_ADDR) begin
        rdata_nxt = br_r;
      end else if (req_i.addr == PACER_DETECT_CONTROL_ADDR) begin
        rdata_nxt = pc_r;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      br_r <= BREATHING_CONTROL_RST;
      pc_r <= FULL_FEATURE ? PACER_DETECT_CONTROL_RST : 24'h000000;
      resp_r <= '{amp_shift: 2'h3, drive_freq_x10: FREQ_STD_0, default: '0};
      rdata_r <= 24'h000000;
      rvalid_r <= 1'b0;
    end else begin
      br_r <= br_nxt;
      pc_r <= pc_nxt;
      resp_r <= resp_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign resp_o = resp_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign pace_o.pulse_width_filter_on = pc_r[PC_PWF_BIT];
  assign pace_o.validation_filter_two_on = pc_r[PC_VF2_BIT];
  assign pace_o.validation_filter_one_on = pc_r[PC_VF1_BIT];
  assign pace_o.detector_three_lead_sel = pc_r[PC_SEL3_LSB +: 2];
  assign pace_o.detector_two_lead_sel = pc_r[PC_SEL2_LSB +: 2];
  assign pace_o.detector_one_lead_sel = pc_r[PC_SEL1_LSB +: 2];
  assign pace_o.detector_three_on = pc_r[PC_DET_LSB + 2];
  assign pace_o.detector_two_on = pc_r[PC_DET_LSB + 1];
  assign pace_o.detector_one_on = pc_r[PC_DET_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic first_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  property p_amp_scaled;
    @(posedge clk_i) disable iff (!nrst_i)
    // /8, /4 and /2 are shifts of 3, 2 and 1 of the full drive
    (resp_o.drive_amplitude_sel != 2'h3) |->
      (resp_o.amp_shift == ((resp_o.drive_amplitude_sel == 2'h0) ? 2'h3 :
      (resp_o.drive_amplitude_sel == 2'h1) ? 2'h2 : 2'h1));
  endproperty
  a_amp_scaled: assert property (p_amp_scaled) else $error("amplitude scale wrong");

  property p_amp_full;
    @(posedge clk_i) disable iff (!nrst_i)
    (resp_o.drive_amplitude_sel == 2'h3) |-> (resp_o.amp_shift == 2'h0);
  endproperty
  a_amp_full: assert property (p_amp_full) else $error("full amplitude not selected");

  property p_freq_std;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_br && !req_i.wdata[BR_ALT_BIT] && req_i.wdata[BR_FREQ_LSB +: 2] == 2'h3) |=>
      (resp_o.drive_freq_x10 == FREQ_STD_3);
  endproperty
  a_freq_std: assert property (p_freq_std) else $error("standard frequency wrong");

  property p_freq_alt;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_br && req_i.wdata[BR_ALT_BIT] && req_i.wdata[BR_FREQ_LSB +: 2] == 2'h1) |=>
      (resp_o.drive_freq_x10 == FREQ_ALT_1);
  endproperty
  a_freq_alt: assert property (p_freq_alt) else $error("alternate frequency wrong");

  property p_resp_on;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_br |=> (resp_o.breathing_measure_on == $past(req_i.wdata[0]));
  endproperty
  a_resp_on: assert property (p_resp_on) else $error("measurement enable not written");

  property p_resp_rst;
    @(posedge clk_i) disable iff (!nrst_i)
    first_r |-> (br_r == BREATHING_CONTROL_RST && !resp_o.breathing_measure_on);
  endproperty
  a_resp_rst: assert property (p_resp_rst) else $error("breathing control reset wrong");

  property p_filters;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_pc |=> ({pace_o.pulse_width_filter_on, pace_o.validation_filter_two_on,
               pace_o.validation_filter_one_on} == $past(req_i.wdata[11:9]));
  endproperty
  a_filters: assert property (p_filters) else $error("filter enables not written");

  property p_leads;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_pc |=> ({pace_o.detector_three_lead_sel, pace_o.detector_two_lead_sel,
               pace_o.detector_one_lead_sel} == $past(req_i.wdata[8:3]));
  endproperty
  a_leads: assert property (p_leads) else $error("lead selectors not written");

  property p_detectors;
    @(posedge clk_i) disable iff (!nrst_i)
    (!wr_pc ##1 !wr_pc) |-> $stable({pace_o.detector_three_on, pace_o.detector_two_on, pace_o.detector_one_on});
  endproperty
  a_detectors: assert property (p_detectors) else $error("detector enables moved without write");

  property p_det_write;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_pc |=> ({pace_o.detector_three_on, pace_o.detector_two_on, pace_o.detector_one_on} ==
      $past(req_i.wdata[PC_DET_LSB +: 3]));
  endproperty
  a_det_write: assert property (p_det_write) else $error("detector enables not written");

  property p_pace_rst;
    @(posedge clk_i) disable iff (!nrst_i)
    (first_r && FULL_FEATURE) |-> (pc_r == PACER_DETECT_CONTROL_RST);
  endproperty
  a_pace_rst: assert property (p_pace_rst) else $error("pacer control reset wrong");

  property p_read_back;
    @(posedge clk_i) disable iff (!nrst_i)
    (req_i.re && !req_i.we && req_i.addr == PACER_DETECT_CONTROL_ADDR) |=> (rvalid_o && rdata_o == $past(pc_r));
  endproperty
  a_read_back: assert property (p_read_back) else $error("pacer read back wrong");

  // a reduced variant must hold nothing and answer every read with zero
  property p_reduced;
    @(posedge clk_i) disable iff (!nrst_i)
    !FULL_FEATURE |-> (br_r == 24'h000000 && pc_r == 24'h000000 && rdata_o == 24'h000000);
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced variant holds state");

  c_resp_alt: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_br && req_i.wdata[BR_ALT_BIT]);
  c_pace_all: cover property (@(posedge clk_i) disable iff (!nrst_i) wr_pc && req_i.wdata[2:0] == 3'h7);
  c_amp_full: cover property (@(posedge clk_i) disable iff (!nrst_i)
    wr_br && req_i.wdata[BR_AMP_LSB +: 2] == AMP_FULL_CODE);
  c_read_br: cover property (@(posedge clk_i) disable iff (!nrst_i)
    req_i.re && req_i.addr == BREATHING_CONTROL_ADDR ##1 rvalid_o);
endmodule

// ---- tb.sv ----
// self-checking bench for the respiration and pace control registers
`timescale 1ns/1ps
module tb;
  import rpc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  rpc_req_t req = '0;
  rpc_resp_t resp;
  rpc_resp_t resp_l;
  rpc_pace_t pace;
  rpc_pace_t pace_l;
  logic [23:0] rdata;
  logic [23:0] rdata_l;
  logic rvalid;
  logic rvalid_l;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [9:0] ftab [8];
  logic [23:0] wd;
  logic [23:0] pd;

  always #25 clk_i = ~clk_i;

  rpc_regs rpc_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .resp_o(resp), .pace_o(pace),
    .rdata_o(rdata), .rvalid_o(rvalid));
  // reduced variant shares the request stream and must stay inert
  rpc_regs #(.FULL_FEATURE(1'b0)) rpc_regs_lite_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
    .resp_o(resp_l), .pace_o(pace_l), .rdata_o(rdata_l), .rvalid_o(rvalid_l));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // inputs move on the falling edge so the rising edge samples them cleanly
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_i);
    req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req = '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    @(negedge clk_i);
    req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 24'h000000};
    @(negedge clk_i);
    req = '0;
    chk("rvalid", 24'h000001, {23'h0, rvalid});
    chk("rdata", exp, rdata);
    chk("lite rdata", 24'h000000, rdata_l);
    chk("lite rvalid", 24'h000001, {23'h0, rvalid_l});
  endtask

  task automatic check_reset();
    rd(6'h03, 24'h000000);
    rd(6'h04, 24'h000f88);
    chk("pace", 24'h000f88, {12'h0, pace});
    chk("amp shift", 24'h000003, {22'h0, resp.amp_shift});
    chk("freq", 24'h000230, {14'h0, resp.drive_freq_x10});
    chk("measure on", 24'h000000, {23'h0, resp.breathing_measure_on});
    chk("lite pace", 24'h000000, {12'h0, pace_l});
    chk("resp", 24'h000e30, {3'h0, resp});
    chk("lite resp", 24'h000e30, {3'h0, resp_l});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    ftab = '{10'h230, 10'h21c, 10'h208, 10'h1f4, 10'h280, 10'h239, 10'h200, 10'h1d1};
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    check_reset();
    // every amplitude, frequency and alternate combination, enable toggling
    for (int i = 0; i < 32; i++) begin
      wd = {15'h0, i[4], i[3:1], i[3:2], i[1:0], ^i[4:0]};
      wr(6'h03, wd);
      chk("amp shift", {22'h0, ~i[3:2]}, {22'h0, resp.amp_shift});
      chk("freq", {14'h0, ftab[{i[4], i[1:0]}]}, {14'h0, resp.drive_freq_x10});
      chk("measure on", {23'h0, ^i[4:0]}, {23'h0, resp.breathing_measure_on});
      chk("resp", {3'h0, ^i[4:0], i[4], i[3:2], i[1:0], i[2:1], i[3], ~i[3:2], ftab[{i[4], i[1:0]}]},
        {3'h0, resp});
      chk("lite resp", 24'h000e30, {3'h0, resp_l});
      rd(6'h03, wd);
    end
    // every lead code on each selector, filters and detectors in mixed states
    for (int i = 0; i < 8; i++) begin
      pd = {12'h0, i[2:0], i[1:0], i[1:0], i[1:0], i[2:0]};
      wr(6'h04, pd);
      chk("pace", pd, {12'h0, pace});
      rd(6'h04, pd);
      chk("lite pace", 24'h000000, {12'h0, pace_l});
    end
    // unmapped address: write ignored, read answers zero
    wr(6'h05, 24'hffffff);
    rd(6'h05, 24'h000000);
    rd(6'h03, wd);
    rd(6'h04, pd);
    // second reset in mid-run restores defaults
    @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    check_reset();
    finish_test();
  end
endmodule
